// File: hw/damping_pkg.sv
/*
 * Constants, types and register map for the loop damping and second phase
 * detector gain configuration bank of the main and auxiliary loops.
 * Assumes an 8-bit register port with byte-wide data on a single clock.
 */
// Summary of operation
// - Main loop damping factor comes from main damping field bits 2 to 0.
// - Auxiliary loop filter damping comes from the auxiliary damping field.
// - Damping factor depends on both the code and the loop bandwidth.
// - Damping fields reset to code 011, a factor of 5 where available.
// - Gain peak is 0.4, 0.2, 0.1, 0.06 or 0.03 dB per factor.
// - Bits 6 to 4 set detector gain for low-rate references in analog mode.
package damping_pkg;

  localparam logic [7:0] MAIN_DAMPING_ADDR   = 8'h6b;
  localparam logic [7:0] AUX_DAMPING_ADDR    = 8'h6a;
  localparam logic [7:0] AUX_GAIN_ADDR       = 8'h6c;

  localparam logic [7:0] DAMPING_RESET       = 8'h13;
  localparam logic [7:0] AUX_GAIN_RESET      = 8'hc2;

  // Damping register: code in [2:0], low-rate analog gain in [6:4].
  localparam int         DAMP_CODE_LSB       = 0;
  localparam int         LOW_GAIN_LSB        = 4;
  // Gain register: digital gain [2:0], high-rate analog [6:4], enable 7.
  localparam int         DIG_GAIN_LSB        = 0;
  localparam int         HIGH_GAIN_LSB       = 4;
  localparam int         GAIN_EN_BIT         = 7;
  localparam logic [7:0] DAMPING_USED_MASK   = 8'h77;
  localparam logic [7:0] GAIN_USED_MASK      = 8'hf7;

  localparam logic [2:0] CODE_FIRST_VALID    = 3'h1;
  localparam logic [2:0] CODE_LAST_VALID     = 3'h5;

  // Gain peak in hundredths of a dB.
  localparam logic [5:0] PEAK_F1P2           = 6'h28;
  localparam logic [5:0] PEAK_F2P5           = 6'h14;
  localparam logic [5:0] PEAK_F5             = 6'h0a;
  localparam logic [5:0] PEAK_F10            = 6'h06;
  localparam logic [5:0] PEAK_F20            = 6'h03;

  typedef enum logic [1:0] {
    BW_UPTO_4HZ,
    BW_8HZ,
    BW_35HZ,
    BW_70HZ
  } bandwidth_t;

  typedef enum logic [2:0] {
    FACTOR_1P2,
    FACTOR_2P5,
    FACTOR_5,
    FACTOR_10,
    FACTOR_20
  } damping_factor_t;

  typedef enum logic {
    FEEDBACK_DIGITAL,
    FEEDBACK_ANALOG
  } feedback_mode_t;

  typedef struct packed {
    damping_factor_t factor;
    logic [5:0]      peak_cdb;
  } loop_filter_t;

  typedef struct packed {
    logic       apply;
    logic [2:0] gain;
  } detector_gain_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

endpackage : damping_pkg

// File: hw/dpll_damping_gain_config.sv
/*
 * Damping and second phase detector gain configuration bank for the main
 * and auxiliary digital loops, with decoded outputs for the loop filters.
 * Assumes the register port master and the loop status inputs (bandwidth,
 * feedback mode, reference rate class) run on i_ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module dpll_damping_gain_config
  import damping_pkg::*;
(
  input  wire logic           i_ref_clk,
  input  wire logic           i_nrst,
  input  wire reg_req_t       i_req,
  input  wire bandwidth_t     i_main_bw,
  input  wire bandwidth_t     i_aux_bw,
  input  wire feedback_mode_t i_aux_mode,
  input  wire logic           i_aux_ref_low_rate,
  output var  logic [7:0]     o_rd_data,
  output var  loop_filter_t   o_main_loop,
  output var  loop_filter_t   o_aux_loop,
  output var  logic [2:0]     o_main_low_rate_analog_gain,
  output var  detector_gain_t o_aux_detector_gain
);

  logic [7:0]      main_damping_reg;
  logic [7:0]      aux_damping_reg;
  logic [7:0]      aux_gain_reg;
  logic [7:0]      rd_data_next;
  loop_filter_t    main_loop_next;
  loop_filter_t    aux_loop_next;
  detector_gain_t  aux_gain_next;

  logic [2:0] main_loop_damping_code;
  logic [2:0] aux_loop_damping_code;
  logic [2:0] main_low_rate_analog_gain;
  logic [2:0] aux_low_rate_analog_gain;
  logic [2:0] aux_high_rate_analog_gain;
  logic [2:0] aux_digital_feedback_gain;
  logic       aux_detector_gain_select_en;

  assign main_loop_damping_code      = main_damping_reg[DAMP_CODE_LSB +: 3];
  assign aux_loop_damping_code       = aux_damping_reg[DAMP_CODE_LSB +: 3];
  assign main_low_rate_analog_gain   = main_damping_reg[LOW_GAIN_LSB +: 3];
  assign aux_low_rate_analog_gain    = aux_damping_reg[LOW_GAIN_LSB +: 3];
  assign aux_high_rate_analog_gain   = aux_gain_reg[HIGH_GAIN_LSB +: 3];
  assign aux_digital_feedback_gain   = aux_gain_reg[DIG_GAIN_LSB +: 3];
  assign aux_detector_gain_select_en = aux_gain_reg[GAIN_EN_BIT];

  function automatic logic code_valid(input logic [2:0] code);
    code_valid = (code >= CODE_FIRST_VALID) && (code <= CODE_LAST_VALID);
  endfunction : code_valid

  // A reserved code keeps the old damping code, the gain field still lands.
  function automatic logic [7:0] damping_write(input logic [7:0] old_val,
                                               input logic [7:0] wdata);
    logic [7:0] val;
    val = wdata & DAMPING_USED_MASK;
    if (!code_valid(wdata[DAMP_CODE_LSB +: 3])) begin
      val[DAMP_CODE_LSB +: 3] = old_val[DAMP_CODE_LSB +: 3];
    end
    damping_write = val;
  endfunction : damping_write

  // Narrow bandwidths offer fewer factors: 4 Hz always gives 5, 8 Hz gives 2.5 for code 1 and 5 otherwise.
  function automatic damping_factor_t factor_of(input logic [2:0] code,
                                                input bandwidth_t bw);
    damping_factor_t f;
    f = FACTOR_5;
    unique case (bw)
      BW_UPTO_4HZ: f = FACTOR_5;
      BW_8HZ: begin
        if (code == 3'h1) begin
          f = FACTOR_2P5;
        end
      end
      BW_35HZ, BW_70HZ: begin
        unique case (code)
          3'h1:    f = FACTOR_1P2;
          3'h2:    f = FACTOR_2P5;
          3'h3:    f = FACTOR_5;
          3'h4:    f = FACTOR_10;
          3'h5:    f = FACTOR_20;
          default: f = FACTOR_5;
        endcase
      end
    endcase
    factor_of = f;
  endfunction : factor_of

  function automatic logic [5:0] peak_of(input damping_factor_t f);
    logic [5:0] p;
    p = PEAK_F5;
    unique case (f)
      FACTOR_1P2: p = PEAK_F1P2;
      FACTOR_2P5: p = PEAK_F2P5;
      FACTOR_5:   p = PEAK_F5;
      FACTOR_10:  p = PEAK_F10;
      FACTOR_20:  p = PEAK_F20;
      default:    p = PEAK_F5;
    endcase
    peak_of = p;
  endfunction : peak_of

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      main_damping_reg <= DAMPING_RESET;
    end else if (i_req.wr && i_req.addr == MAIN_DAMPING_ADDR) begin
      main_damping_reg <= damping_write(main_damping_reg,
                                        i_req.wdata);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      aux_damping_reg <= DAMPING_RESET;
    end else if (i_req.wr && i_req.addr == AUX_DAMPING_ADDR) begin
      aux_damping_reg <= damping_write(aux_damping_reg, i_req.wdata);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      aux_gain_reg <= AUX_GAIN_RESET;
    end else if (i_req.wr && i_req.addr == AUX_GAIN_ADDR) begin
      aux_gain_reg <= i_req.wdata & GAIN_USED_MASK;
    end
  end

  // Unmapped addresses read zero; data stands only in the cycle after.
  always_comb begin
    rd_data_next = 8'h00;
    if (i_req.rd) begin
      unique case (i_req.addr)
        MAIN_DAMPING_ADDR: rd_data_next = main_damping_reg;
        AUX_DAMPING_ADDR:  rd_data_next = aux_damping_reg;
        AUX_GAIN_ADDR:     rd_data_next = aux_gain_reg;
        default:           rd_data_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rd_data <= 8'h00;
    end else begin
      o_rd_data <= rd_data_next;
    end
  end

  always_comb begin
    main_loop_next.factor   = factor_of(main_loop_damping_code,
                                        i_main_bw);
    main_loop_next.peak_cdb = peak_of(main_loop_next.factor);
    aux_loop_next.factor    = factor_of(aux_loop_damping_code,
                                        i_aux_bw);
    aux_loop_next.peak_cdb  = peak_of(aux_loop_next.factor);
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_main_loop <= '{factor: FACTOR_5, peak_cdb: PEAK_F5};
      o_aux_loop  <= '{factor: FACTOR_5, peak_cdb: PEAK_F5};
    end else begin
      o_main_loop <= main_loop_next;
      o_aux_loop  <= aux_loop_next;
    end
  end

  // With selection off the loop keeps its built-in gain, so nothing applies.
  always_comb begin
    aux_gain_next = '{apply: 1'b0, gain: 3'h0};
    if (aux_detector_gain_select_en) begin
      aux_gain_next.apply = 1'b1;
      if (i_aux_mode == FEEDBACK_DIGITAL) begin
        aux_gain_next.gain = aux_digital_feedback_gain;
      end else if (i_aux_ref_low_rate) begin
        aux_gain_next.gain = aux_low_rate_analog_gain;
      end else begin
        aux_gain_next.gain = aux_high_rate_analog_gain;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_aux_detector_gain         <= '{apply: 1'b0, gain: 3'h0};
      o_main_low_rate_analog_gain <= 3'h0;
    end else begin
      o_aux_detector_gain         <= aux_gain_next;
      o_main_low_rate_analog_gain <= main_low_rate_analog_gain;
    end
  end

  default clocking cb @(posedge i_ref_clk);
  endclocking

  default disable iff (!i_nrst);

  property read_back_p(logic [7:0] addr, logic [7:0] value);
    (i_req.rd && i_req.addr == addr) |=> (o_rd_data == $past(value));
  endproperty

  main_damping_readback_a: assert property (
    read_back_p(MAIN_DAMPING_ADDR, main_damping_reg))
    else $error("Main damping register read back wrong.");

  aux_damping_readback_a: assert property (
    read_back_p(AUX_DAMPING_ADDR, aux_damping_reg))
    else $error("Auxiliary damping register read back wrong.");

  aux_gain_readback_a: assert property (
    read_back_p(AUX_GAIN_ADDR, aux_gain_reg))
    else $error("Auxiliary gain register read back wrong.");

  reserved_code_kept_a: assert property (
    (i_req.wr && i_req.addr == MAIN_DAMPING_ADDR
      && !code_valid(i_req.wdata[2:0]))
    |=> main_loop_damping_code == $past(main_loop_damping_code))
    else $error("Reserved damping code altered the field.");

  aux_reserved_kept_a: assert property (
    (i_req.wr && i_req.addr == AUX_DAMPING_ADDR
      && !code_valid(i_req.wdata[2:0]))
    |=> aux_loop_damping_code == $past(aux_loop_damping_code))
    else $error("Reserved damping code altered the auxiliary field.");

  unused_bits_zero_a: assert property (
    (main_damping_reg[7] == 1'b0) && (main_damping_reg[3] == 1'b0)
      && (aux_damping_reg[7] == 1'b0) && (aux_damping_reg[3] == 1'b0)
      && (aux_gain_reg[3] == 1'b0))
    else $error("Unused register bit is set.");

  narrow_bw_factor_a: assert property (
    (i_main_bw == BW_UPTO_4HZ) |=> (o_main_loop.factor == FACTOR_5))
    else $error("Narrow bandwidth did not give a factor of five.");

  wide_bw_code_a: assert property (
    (i_aux_bw == BW_70HZ && aux_loop_damping_code == 3'h5)
      ##1 (i_aux_bw == BW_70HZ && aux_loop_damping_code == 3'h5)
    |=> (o_aux_loop.factor == FACTOR_20) [*1])
    else $error("Wide bandwidth code five did not give twenty.");

  mid_bw_factor_a: assert property (
    (i_aux_bw == BW_8HZ && aux_loop_damping_code == 3'h1)
    |=> (o_aux_loop.factor == FACTOR_2P5))
    else $error("Code one at 8 Hz did not give 2.5.");

  peak_matches_factor_a: assert property (
    (o_main_loop.factor == FACTOR_1P2) |-> (o_main_loop.peak_cdb == 6'h28))
    else $error("Gain peak does not match factor 1.2.");

  gain_off_a: assert property (
    !aux_detector_gain_select_en |=> !o_aux_detector_gain.apply)
    else $error("Detector gain applied while selection is off.");

  low_rate_gain_a: assert property (
    (aux_detector_gain_select_en && i_aux_mode == FEEDBACK_ANALOG
      && i_aux_ref_low_rate)
    |=> (o_aux_detector_gain.gain == $past(aux_low_rate_analog_gain)))
    else $error("Low-rate analog gain not selected.");

  digital_gain_a: assert property (
    (aux_detector_gain_select_en && i_aux_mode == FEEDBACK_DIGITAL)
    |=> (o_aux_detector_gain.gain == $past(aux_digital_feedback_gain)))
    else $error("Digital feedback gain not selected.");

  high_rate_gain_a: assert property (
    (aux_detector_gain_select_en && i_aux_mode == FEEDBACK_ANALOG
      && !i_aux_ref_low_rate)
    |=> (o_aux_detector_gain.gain == $past(aux_high_rate_analog_gain)))
    else $error("High-rate analog gain not selected.");

  reset_code_a: assert property (
    $rose(i_nrst) |-> (main_loop_damping_code == 3'h3
      && aux_loop_damping_code == 3'h3))
    else $error("Damping code not 011 after reset.");

  read_pulse_only_a: assert property (
    !i_req.rd |=> (o_rd_data == 8'h00))
    else $error("Read data stood outside the read answer cycle.");

  main_low_gain_a: assert property (
    1'b1 |=> (o_main_low_rate_analog_gain
              == $past(main_low_rate_analog_gain)))
    else $error("Main low-rate gain output does not follow its field.");

  main_write_cov: cover property (
    i_req.wr && i_req.addr == MAIN_DAMPING_ADDR ##1 i_req.rd
      && i_req.addr == MAIN_DAMPING_ADDR);

  reserved_write_cov: cover property (
    i_req.wr && i_req.addr == AUX_DAMPING_ADDR
      && !code_valid(i_req.wdata[2:0]));

  analog_low_cov: cover property (
    o_aux_detector_gain.apply && i_aux_mode == FEEDBACK_ANALOG
      && i_aux_ref_low_rate);

  factor_twenty_cov: cover property (o_main_loop.factor == FACTOR_20);

  digital_gain_cov: cover property (
    o_aux_detector_gain.apply && i_aux_mode == FEEDBACK_DIGITAL);

endmodule : dpll_damping_gain_config

`default_nettype wire

// File: bench/dpll_damping_gain_config_tb.sv
/*
 * Self-checking bench for the loop damping and detector gain bank.
 * Assumes one 125 MHz clock and the single-cycle register port of the block.
 */
`timescale 1ns/1ps
`default_nettype none

module dpll_damping_gain_config_tb;
  import damping_pkg::*;

  logic           i_ref_clk;
  logic           i_nrst;
  reg_req_t       i_req;
  bandwidth_t     i_main_bw;
  bandwidth_t     i_aux_bw;
  feedback_mode_t i_aux_mode;
  logic           i_aux_ref_low_rate;
  logic [7:0]     o_rd_data;
  loop_filter_t   o_main_loop;
  loop_filter_t   o_aux_loop;
  logic [2:0]     o_main_low_rate_analog_gain;
  detector_gain_t o_aux_detector_gain;
  int             err_total;
  int             compares;
  int             cycles;
  integer         seed;
  logic [31:0]    r;
  logic [7:0]     main_exp;
  logic [7:0]     aux_exp;
  logic [7:0]     gain_exp;

  dpll_damping_gain_config dpll_damping_gain_config_i (
    .i_ref_clk                   (i_ref_clk),
    .i_nrst                      (i_nrst),
    .i_req                       (i_req),
    .i_main_bw                   (i_main_bw),
    .i_aux_bw                    (i_aux_bw),
    .i_aux_mode                  (i_aux_mode),
    .i_aux_ref_low_rate          (i_aux_ref_low_rate),
    .o_rd_data                   (o_rd_data),
    .o_main_loop                 (o_main_loop),
    .o_aux_loop                  (o_aux_loop),
    .o_main_low_rate_analog_gain (o_main_low_rate_analog_gain),
    .o_aux_detector_gain         (o_aux_detector_gain)
  );

  initial begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end

  task automatic finish_test();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  // The whole run needs at most about 1220 cycles, so 5000 leaves ample margin.
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      finish_test();
    end
  end

  task automatic check_byte(input string what, input logic [7:0] e,
                            input logic [7:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : check_byte

  task automatic check_loop(input string what, input loop_filter_t e,
                            input loop_filter_t g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : check_loop

  task automatic check_gain(input string what, input detector_gain_t e,
                            input detector_gain_t g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : check_gain

  function automatic loop_filter_t exp_loop(input logic [2:0] code,
                                            input bandwidth_t bw);
    damping_factor_t f;
    f = FACTOR_5;
    if (bw == BW_8HZ && code == 3'h1) f = FACTOR_2P5;
    else if (bw == BW_35HZ || bw == BW_70HZ)
      f = damping_factor_t'(code - 3'h1);
    case (f)
      FACTOR_1P2: return '{f, 6'h28};
      FACTOR_2P5: return '{f, 6'h14};
      FACTOR_10:  return '{f, 6'h06};
      FACTOR_20:  return '{f, 6'h03};
      default:    return '{f, 6'h0a};
    endcase
  endfunction : exp_loop

  function automatic detector_gain_t exp_gain();
    if (!gain_exp[7]) return '{1'b0, 3'h0};
    if (i_aux_mode == FEEDBACK_DIGITAL) return '{1'b1, gain_exp[2:0]};
    return '{1'b1, i_aux_ref_low_rate ? aux_exp[6:4] : gain_exp[6:4]};
  endfunction : exp_gain

  // A reserved damping code leaves the old code in place.
  function automatic logic [7:0] damp_next(input logic [7:0] old,
                                           input logic [7:0] d);
    logic ok;
    ok = (d[2:0] >= 3'h1) && (d[2:0] <= 3'h5);
    return {1'b0, d[6:4], 1'b0, ok ? d[2:0] : old[2:0]};
  endfunction : damp_next

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_ref_clk);
    i_req.wr <= 1'b0;
    if (a == MAIN_DAMPING_ADDR) main_exp = damp_next(main_exp, d);
    if (a == AUX_DAMPING_ADDR) aux_exp = damp_next(aux_exp, d);
    if (a == AUX_GAIN_ADDR) gain_exp = d & 8'hf7;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_ref_clk);
    i_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_ref_clk);
    i_req.rd <= 1'b0;
    #1;
    check_byte("read data", e, o_rd_data);
    @(posedge i_ref_clk);
    #1;
    check_byte("idle read data", 8'h00, o_rd_data);
  endtask : reg_read

  task automatic read_all();
    reg_read(MAIN_DAMPING_ADDR, main_exp);
    reg_read(AUX_DAMPING_ADDR, aux_exp);
    reg_read(AUX_GAIN_ADDR, gain_exp);
    reg_read(8'h00, 8'h00);
  endtask : read_all

  task automatic check_outputs();
    repeat (2) @(posedge i_ref_clk);
    #1;
    check_loop("main loop", exp_loop(main_exp[2:0], i_main_bw),
               o_main_loop);
    check_loop("aux loop", exp_loop(aux_exp[2:0], i_aux_bw),
               o_aux_loop);
    check_byte("main gain", {5'h0, main_exp[6:4]},
               {5'h0, o_main_low_rate_analog_gain});
    check_gain("aux gain", exp_gain(), o_aux_detector_gain);
  endtask : check_outputs

  initial begin
    seed = 32'h3f6b;
    err_total = 0;
    compares = 0;
    cycles = 0;
    i_nrst = 1'b0;
    i_req = '0;
    i_main_bw = BW_70HZ;
    i_aux_bw = BW_8HZ;
    i_aux_mode = FEEDBACK_ANALOG;
    i_aux_ref_low_rate = 1'b1;
    main_exp = 8'h13;
    aux_exp = 8'h13;
    gain_exp = 8'hc2;
    repeat (16) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    check_outputs();
    read_all();
    for (int c = 0; c < 8; c++) begin
      reg_write(MAIN_DAMPING_ADDR,
                {1'b1, 3'(c + 1), 1'b1, 3'(c)});
      reg_write(AUX_DAMPING_ADDR,
                {1'b1, 3'(7 - c), 1'b1, 3'(c)});
      for (int b = 0; b < 4; b++) begin
        @(posedge i_ref_clk);
        i_main_bw <= bandwidth_t'(b);
        i_aux_bw <= bandwidth_t'(3 - b);
        check_outputs();
      end
    end
    reg_write(AUX_GAIN_ADDR, 8'h7f);
    check_outputs();
    reg_write(8'h6d, 8'h55);
    read_all();
    // Write and read back to back: the new value must show with no gap.
    @(posedge i_ref_clk);
    i_req <= '{addr: MAIN_DAMPING_ADDR, wdata: 8'h24, wr: 1'b1, rd: 1'b0};
    @(posedge i_ref_clk);
    i_req <= '{addr: MAIN_DAMPING_ADDR, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    main_exp = damp_next(main_exp, 8'h24);
    @(posedge i_ref_clk);
    i_req.rd <= 1'b0;
    #1;
    check_byte("back to back read", main_exp, o_rd_data);
    for (int n = 0; n < 60; n++) begin
      r = $random(seed);
      case (r[1:0])
        2'h0: reg_write(MAIN_DAMPING_ADDR, r[15:8]);
        2'h1: reg_write(AUX_DAMPING_ADDR, r[15:8]);
        2'h2: reg_write(AUX_GAIN_ADDR, r[15:8]);
        default: reg_write(r[23:16], r[15:8]);
      endcase
      @(posedge i_ref_clk);
      i_main_bw <= bandwidth_t'(r[25:24]);
      i_aux_bw <= bandwidth_t'(r[27:26]);
      i_aux_mode <= feedback_mode_t'(r[28]);
      i_aux_ref_low_rate <= r[29];
      check_outputs();
      if (r[30]) read_all();
    end
    // A second reset in mid-run must bring every field back to its default.
    @(posedge i_ref_clk);
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    main_exp = DAMPING_RESET;
    aux_exp = DAMPING_RESET;
    gain_exp = AUX_GAIN_RESET;
    check_outputs();
    read_all();
    finish_test();
  end
endmodule : dpll_damping_gain_config_tb

`default_nettype wire
